// file: hw/cmd_status_pkg.sv
/*
 package for the primary command/status/revision register bank:
 offsets, bit positions, reset values, bus carriers.
 assumes an apb master with 32-bit data, aligned word access.
*/
package cmd_status_pkg;
   localparam logic [7:0] cmd_status_off = 8'h04;
   localparam logic [7:0] revision_off = 8'h08;
   localparam int io_en_bit = 0;
   localparam int mem_en_bit = 1;
   localparam int master_en_bit = 2;
   localparam int vga_snoop_bit = 5;
   localparam int parity_resp_bit = 6;
   localparam int serr_en_bit = 8;
   localparam int fast_b2b_bit = 9;
   localparam int stat_cap_list_bit = 20;
   localparam int stat_66mhz_bit = 21;
   localparam int stat_fb2b_cap_bit = 23;
   localparam int stat_dpe_bit = 24;
   localparam int stat_devsel_lo_bit = 25;
   localparam int stat_sta_bit = 27;
   localparam int stat_rta_bit = 28;
   localparam int stat_rma_bit = 29;
   localparam int stat_sse_bit = 30;
   localparam int stat_dpd_bit = 31;
   localparam logic [9:0] cmd_rw_mask = 10'h367;
   localparam logic [9:0] cmd_reset = 10'h000;
   localparam logic [4:0] stat_flags_reset = 5'h00;
   localparam logic [1:0] devsel_medium = 2'h1;
   localparam logic [9:0] vga_pal_a = 10'h3c6;
   localparam logic [9:0] vga_pal_b = 10'h3c8;
   localparam logic [9:0] vga_pal_c = 10'h3c9;

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed
   {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

   // error events seen on the primary side, one-cycle pulses
   typedef struct packed
   {
      logic parity_err;
      logic target_abort_sig;
      logic target_abort_rcv;
      logic master_abort_rcv;
      logic serr_asserted;
      logic addr_data_parity_err;
   } err_event_t;
endpackage : cmd_status_pkg

// file: hw/cmd_status_regs.sv
/*
 primary command, status and revision registers of the bridge.
 assumes a synchronous apb master on pclk and event inputs already
 synchronised to pclk by the primary bus logic.
*/
// Register access over APB is this design's own decision.
// Operation
// - io claims only while command bit 0
// - memory response only while command bit 1
// - bus master enable gates mastering, secondary
// - special cycle bit reads zero
// - memory write invalidate bit reads zero
// - vga palette decode 3c6 3c8 3c9
// - parity response bit gates parity actions
// - stepping bit read-only zero
// - system error driver only while bit 8
// - fast back-to-back only while bit 9
// - command bits 15:10 read zero
// - capability list bit reads one
// - 66 mhz capable bit reads one
// - fast back-to-back capable reads one
// - data parity flag on perr, bit 6
// - devsel timing fixed medium
// - signaled target abort flag
// - received target abort flag
// - received master abort flag
// - signaled system error flag
// - detected parity error flag, always
// - hardwired 8-bit revision code
`timescale 1ns/1ps
module cmd_status_regs #(
   // arbitrary neutral revision code
   parameter logic [7:0] revision_code = 8'h5a
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire cmd_status_pkg::apb_req_t apb_req,
   output cmd_status_pkg::apb_rsp_t apb_rsp,
   input wire cmd_status_pkg::err_event_t err_event,
   input wire logic [9:0] io_addr_low,
   input wire logic io_write,
   output logic io_claim_en,
   output logic mem_claim_en,
   output logic master_en,
   output logic sec1_accept_en,
   output logic vga_palette_hit,
   output logic parity_action_en,
   output logic fast_b2b_en,
   output logic primary_system_error_out,
   output logic primary_system_error_oe_n
);
   ////////////////////////////////////////////////////////////////////
   logic [9:0] cmd_r;
   logic [4:0] flags_r;
   logic [4:0] flags_nxt;
   logic [31:0] rdata_r;
   logic [31:0] cmd_word;
   logic wr_cmd;
   logic rd_access;
   logic dpe_set;
   logic [4:0] flag_set;
   logic rd_setup;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   function automatic logic vga_match(input logic [9:0] a);
      vga_match = (a == cmd_status_pkg::vga_pal_a) ||
                  (a == cmd_status_pkg::vga_pal_b) ||
                  (a == cmd_status_pkg::vga_pal_c);
   endfunction : vga_match

   ////////////////////////////////////////////////////////////////////
   // zero-wait slave: answer in the access cycle
   assign rd_access = apb_req.psel && apb_req.penable && !apb_req.pwrite;
   assign wr_cmd = apb_req.psel && apb_req.penable && apb_req.pwrite &&
                   (apb_req.paddr == cmd_status_pkg::cmd_status_off);
   assign rd_setup = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = 1'b0;
   assign apb_rsp.prdata = rdata_r;

   // writable bits only; 3,4,7 and 15:10 stay zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cmd_r <= cmd_status_pkg::cmd_reset;
      else if (wr_cmd)
         cmd_r <= apb_req.pwdata[9:0] & cmd_status_pkg::cmd_rw_mask;
   end

   ////////////////////////////////////////////////////////////////////
   assign io_claim_en = cmd_r[cmd_status_pkg::io_en_bit];
   assign mem_claim_en = cmd_r[cmd_status_pkg::mem_en_bit];
   assign master_en = cmd_r[cmd_status_pkg::master_en_bit];
   assign sec1_accept_en = cmd_r[cmd_status_pkg::master_en_bit];
   // isa aliases kept: upper address bits not looked at
   assign vga_palette_hit = cmd_r[cmd_status_pkg::vga_snoop_bit] &&
                            io_write && vga_match(io_addr_low);
   assign parity_action_en = cmd_r[cmd_status_pkg::parity_resp_bit];
   assign fast_b2b_en = cmd_r[cmd_status_pkg::fast_b2b_bit];
   // open-drain: low level driven only when enabled
   assign primary_system_error_out = 1'b0;
   assign primary_system_error_oe_n =
      !(cmd_r[cmd_status_pkg::serr_en_bit] && err_event.serr_asserted);

   ////////////////////////////////////////////////////////////////////
   // flags order: dpe, sta, rta, rma, sse (bits 24,27..30) plus dpd
   logic dpd_r;
   assign dpe_set = err_event.parity_err &&
                    cmd_r[cmd_status_pkg::parity_resp_bit];
   assign flag_set = {err_event.serr_asserted &&
                      cmd_r[cmd_status_pkg::serr_en_bit],
                      err_event.master_abort_rcv,
                      err_event.target_abort_rcv,
                      err_event.target_abort_sig,
                      dpe_set};
   // set wins over a write-one clear in the same cycle
   assign flags_nxt = flag_set | (flags_r & ~({5{wr_cmd}} &
                      {apb_req.pwdata[30:27], apb_req.pwdata[24]}));

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flags_r <= cmd_status_pkg::stat_flags_reset;
      else
         flags_r <= flags_nxt;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dpd_r <= 1'b0;
      else
         dpd_r <= err_event.addr_data_parity_err ||
                  (dpd_r && !(wr_cmd && apb_req.pwdata[31]));
   end

   ////////////////////////////////////////////////////////////////////
   always_comb
   begin
      cmd_word = 32'h0000_0000;
      cmd_word[9:0] = cmd_r;
      cmd_word[cmd_status_pkg::stat_cap_list_bit] = 1'b1;
      cmd_word[cmd_status_pkg::stat_66mhz_bit] = 1'b1;
      cmd_word[cmd_status_pkg::stat_fb2b_cap_bit] = 1'b1;
      cmd_word[cmd_status_pkg::stat_dpe_bit] = flags_r[0];
      cmd_word[26:25] = cmd_status_pkg::devsel_medium;
      cmd_word[30:27] = flags_r[4:1];
      cmd_word[cmd_status_pkg::stat_dpd_bit] = dpd_r;
   end

   // read data registered in setup so it stands in the access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rdata_r <= 32'h0000_0000;
      else if (rd_setup)
         case (apb_req.paddr)
            cmd_status_pkg::cmd_status_off: rdata_r <= cmd_word;
            cmd_status_pkg::revision_off:
               rdata_r <= {24'h00_0000, revision_code};
            default: rdata_r <= 32'h0000_0000;
         endcase
   end

   ////////////////////////////////////////////////////////////////////
   sticky_flag_a: assert property (
      err_event.target_abort_rcv |=>
      flags_r[2])
      else $error("received target abort not latched");

   dpe_gate_a: assert property (
      (err_event.parity_err && !parity_action_en && !flags_r[0]) |=>
      !flags_r[0])
      else $error("parity flag set without enable");

   dpd_any_a: assert property (
      err_event.addr_data_parity_err |=>
      dpd_r)
      else $error("detected parity error not latched");

   clear_hold_a: assert property (
      wr_cmd && apb_req.pwdata[29] && !err_event.master_abort_rcv |=>
      !flags_r[3])
      else $error("write one did not clear");

   zero_keep_a: assert property (
      flags_r[1] && wr_cmd && !apb_req.pwdata[27] |=>
      flags_r[1])
      else $error("write zero cleared a flag");

   serr_gate_a: assert property (
      !cmd_r[cmd_status_pkg::serr_en_bit] |->
      primary_system_error_oe_n)
      else $error("system error driven while disabled");

   cmd_ro_a: assert property (
      wr_cmd |=> !cmd_r[3] && !cmd_r[4] && !cmd_r[7] &&
      (cmd_r[0] == $past(apb_req.pwdata[0])))
      else $error("command write image wrong");

   vga_dec_a: assert property (
      vga_palette_hit |-> cmd_r[5] && io_write &&
      (io_addr_low[9:4] == 6'h3c))
      else $error("palette decode outside window");

   sse_flag_a: assert property (
      err_event.serr_asserted && cmd_r[cmd_status_pkg::serr_en_bit] |=>
      flags_r[4])
      else $error("signaled system error not latched");

   rd_rev_a: assert property (
      rd_setup && apb_req.paddr == cmd_status_pkg::revision_off |=>
      rdata_r[7:0] == revision_code)
      else $error("revision read wrong");

   io_wr_a: assert property (
      wr_cmd |=> io_claim_en ==
      $past(apb_req.pwdata[cmd_status_pkg::io_en_bit]))
      else $error("io enable not loaded");

   mem_wr_a: assert property (
      wr_cmd |=> mem_claim_en ==
      $past(apb_req.pwdata[cmd_status_pkg::mem_en_bit]))
      else $error("memory enable not loaded");

   mst_wr_a: assert property (
      wr_cmd |=> master_en ==
      $past(apb_req.pwdata[cmd_status_pkg::master_en_bit]))
      else $error("master enable not loaded");

   sec1_wr_a: assert property (
      wr_cmd |=> sec1_accept_en ==
      $past(apb_req.pwdata[cmd_status_pkg::master_en_bit]))
      else $error("secondary accept enable not loaded");

   snoop_wr_a: assert property (
      wr_cmd |=> cmd_r[cmd_status_pkg::vga_snoop_bit] ==
      $past(apb_req.pwdata[cmd_status_pkg::vga_snoop_bit]))
      else $error("palette snoop enable not loaded");

   par_wr_a: assert property (
      wr_cmd |=> parity_action_en ==
      $past(apb_req.pwdata[cmd_status_pkg::parity_resp_bit]))
      else $error("parity response enable not loaded");

   serr_wr_a: assert property (
      wr_cmd |=> cmd_r[cmd_status_pkg::serr_en_bit] ==
      $past(apb_req.pwdata[cmd_status_pkg::serr_en_bit]))
      else $error("system error enable not loaded");

   fb2b_wr_a: assert property (
      wr_cmd |=> fast_b2b_en ==
      $past(apb_req.pwdata[cmd_status_pkg::fast_b2b_bit]))
      else $error("fast back-to-back enable not loaded");

   cmd_hold_a: assert property (
      !wr_cmd |=>
      $stable(cmd_r))
      else $error("command changed without a write");

   wr_other_a: assert property (
      apb_req.psel && apb_req.penable && apb_req.pwrite &&
      apb_req.paddr != cmd_status_pkg::cmd_status_off |=> $stable(cmd_r))
      else $error("write to another offset changed command");

   rsvd_cmd_a: assert property (
      cmd_word[15:10] == 6'h00 && cmd_word[4:3] == 2'h0 &&
      !cmd_word[7])
      else $error("read-only command bits not zero");

   cap_bits_a: assert property (
      cmd_word[cmd_status_pkg::stat_cap_list_bit] &&
      cmd_word[cmd_status_pkg::stat_66mhz_bit])
      else $error("capability bits not one");

   fb2b_cap_a: assert property (
      cmd_word[cmd_status_pkg::stat_fb2b_cap_bit] &&
      cmd_word[19:16] == 4'h0 && !cmd_word[22])
      else $error("fixed status bits wrong");

   devsel_a: assert property (
      cmd_word[26:25] ==
      cmd_status_pkg::devsel_medium)
      else $error("devsel timing field wrong");

   rd_cmd_a: assert property (
      rd_setup && apb_req.paddr == cmd_status_pkg::cmd_status_off |=>
      rdata_r == $past(cmd_word))
      else $error("command status read wrong");

   rd_unmap_a: assert property (
      rd_setup && apb_req.paddr != cmd_status_pkg::cmd_status_off &&
      apb_req.paddr != cmd_status_pkg::revision_off |=> rdata_r == '0)
      else $error("unmapped read not zero");

   rd_hold_a: assert property (
      !rd_setup |=>
      $stable(rdata_r))
      else $error("read data moved outside a read");

   rev_acc_a: assert property (
      rd_access && apb_req.paddr == cmd_status_pkg::revision_off |->
      apb_rsp.prdata[7:0] == revision_code)
      else $error("revision not presented in access");

   sta_set_a: assert property (
      err_event.target_abort_sig |=>
      flags_r[1])
      else $error("signaled target abort not latched");

   rma_set_a: assert property (
      err_event.master_abort_rcv |=>
      flags_r[3])
      else $error("received master abort not latched");

   dpe_set_a: assert property (
      err_event.parity_err && parity_action_en |=>
      flags_r[0])
      else $error("data parity flag not latched");

   sse_gate_a: assert property (
      (err_event.serr_asserted && !cmd_r[cmd_status_pkg::serr_en_bit] &&
      !flags_r[4]) |=> !flags_r[4])
      else $error("system error flag set while disabled");

   set_wins_a: assert property (
      wr_cmd && apb_req.pwdata[28] && err_event.target_abort_rcv |=>
      flags_r[2])
      else $error("clear beat a new event");

   dpd_wins_a: assert property (
      wr_cmd && apb_req.pwdata[31] && err_event.addr_data_parity_err |=>
      dpd_r)
      else $error("clear beat a new parity event");

   dpd_clr_a: assert property (
      wr_cmd && apb_req.pwdata[31] && !err_event.addr_data_parity_err
      |=> !dpd_r)
      else $error("detected parity flag not cleared");

   flag_hold_a: assert property (
      !wr_cmd && err_event == '0 |=>
      $stable(flags_r) && $stable(dpd_r))
      else $error("status flag moved without cause");

   serr_drive_a: assert property (
      err_event.serr_asserted && cmd_r[cmd_status_pkg::serr_en_bit] |->
      !primary_system_error_oe_n)
      else $error("system error not driven");

   serr_low_a: assert property (
      1'b1 |->
      primary_system_error_out == 1'b0)
      else $error("system error level not low");

   vga_hit_a: assert property (
      cmd_r[cmd_status_pkg::vga_snoop_bit] && io_write &&
      vga_match(io_addr_low) |-> vga_palette_hit)
      else $error("palette write not claimed");

   vga_off_a: assert property (
      !cmd_r[cmd_status_pkg::vga_snoop_bit] |->
      !vga_palette_hit)
      else $error("palette claimed while disabled");

   wr_cmd_c: cover property (wr_cmd);
   set_clr_c: cover property (wr_cmd && apb_req.pwdata[28] &&
      err_event.target_abort_rcv);
   vga_c: cover property (vga_palette_hit);
   serr_c: cover property (!primary_system_error_oe_n);
   dpd_c: cover property (wr_cmd && apb_req.pwdata[31] && dpd_r);
endmodule : cmd_status_regs

// file: dv/err_event_src.sv
/*
 primary-side event source standing in for the bridge's bus logic.
 assumes the bench raises fire for exactly one pclk cycle.
*/
`timescale 1ns/1ps
module err_event_src
(
   input wire logic pclk,
   input wire logic presetn,
   input wire cmd_status_pkg::err_event_t fire,
   output cmd_status_pkg::err_event_t err_event
);
   ////////////////////////////////////////////////////////////
   // registered so every event reaches the bank as one clean pulse
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         err_event <= 6'h00;
      else
         err_event <= fire;
   end
endmodule : err_event_src

// file: dv/tb_top.sv
/*
 self-checking bench for the primary command/status/revision bank.
 assumes a one-clock apb slave and pulse events from err_event_src.
*/
`timescale 1ns/1ps
module tb_top;
   logic pclk, presetn, io_write, io_claim_en, mem_claim_en, master_en;
   logic sec1_accept_en, vga_palette_hit, parity_action_en, fast_b2b_en;
   logic serr_out, serr_oe_n;
   logic [9:0] io_addr_low, a;
   logic [15:0] cmd_m;
   logic [31:0] st_m, q, d;
   logic [5:0] e;
   integer n_errors = 0, n_tests = 0, seed = 13, cyc = 0, i;
   cmd_status_pkg::apb_req_t req;
   cmd_status_pkg::apb_rsp_t rsp;
   cmd_status_pkg::err_event_t fire, ev;
   ////////////////////////////////////////////////////////////
   cmd_status_regs #(.revision_code(8'h3c)) u_dut (.pclk(pclk),
      .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .err_event(ev),
      .io_addr_low(io_addr_low), .io_write(io_write),
      .io_claim_en(io_claim_en), .mem_claim_en(mem_claim_en),
      .master_en(master_en), .sec1_accept_en(sec1_accept_en),
      .vga_palette_hit(vga_palette_hit),
      .parity_action_en(parity_action_en), .fast_b2b_en(fast_b2b_en),
      .primary_system_error_out(serr_out),
      .primary_system_error_oe_n(serr_oe_n));
   err_event_src u_src (.pclk(pclk), .presetn(presetn), .fire(fire),
      .err_event(ev));
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////
   task end_of_test;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_errors = n_errors + 1;
         end_of_test();
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] x);
      n_tests = n_tests + 1;
      if (g !== x)
      begin
         n_errors = n_errors + 1;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   // holds the request until pready is seen at an edge
   task xfer(input logic w, input logic [7:0] ad, input logic [31:0] wd,
      output logic [31:0] r);
      @(posedge pclk);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= w;
      req.paddr <= ad;
      req.pwdata <= wd;
      @(posedge pclk);
      req.penable <= 1'b1;
      @(posedge pclk);
      while (rsp.pready !== 1'b1)
         @(posedge pclk);
      r = rsp.prdata;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : xfer
   // fixed status bits 23..16 read b0, devsel field reads 01
   function automatic logic [31:0] stw();
      return {st_m[31:27], 2'h1, st_m[24], 8'hb0, cmd_m};
   endfunction : stw
   task pulse(input logic [5:0] x);
      @(posedge pclk);
      fire <= x;
      @(posedge pclk);
      fire <= 6'h00;
      @(negedge pclk);
      chk({serr_oe_n, serr_out}, {~(x[1] & cmd_m[8]), 1'b0});
      st_m[24] = st_m[24] | (x[5] & cmd_m[6]);
      st_m[31:27] = st_m[31:27] | {x[0], x[1] & cmd_m[8], x[2], x[3], x[4]};
   endtask : pulse
   ////////////////////////////////////////////////////////////
   initial
   begin
      req = '0;
      fire = 6'h00;
      io_write = 1'b0;
      io_addr_low = 10'h000;
      presetn = 1'b0;
      cmd_m = 16'h0000;
      st_m = 32'h00000000;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk({io_claim_en, mem_claim_en, master_en, sec1_accept_en,
         parity_action_en, fast_b2b_en, vga_palette_hit, serr_oe_n,
         serr_out}, 9'h002);
      xfer(1'b0, 8'h04, 32'h0, q);
      chk(q, stw());
      xfer(1'b1, 8'h08, 32'hffffffff, q);
      xfer(1'b0, 8'h08, 32'h0, q);
      chk(q, 32'h0000003c);
      xfer(1'b0, 8'h0c, 32'h0, q);
      chk(q, 32'h00000000);
      for (i = 0; i < 40; i = i + 1)
      begin
         d = $random(seed);
         e = 6'($random(seed));
         if (i == 1)
         begin
            d = 32'h0000ffff;
            e = 6'h3f;
         end
         xfer(1'b1, 8'h04, d, q);
         cmd_m = d[15:0] & 16'h0367;
         st_m = st_m & ~(d & 32'hf9000000);
         a = (i % 4 == 0) ? 10'h3c6 : (i % 4 == 1) ? 10'h3c8 :
            (i % 4 == 2) ? 10'h3c9 : 10'($random(seed));
         io_addr_low <= a;
         io_write <= e[0];
         @(negedge pclk);
         chk({fast_b2b_en, parity_action_en, sec1_accept_en, master_en,
            mem_claim_en, io_claim_en}, {cmd_m[9], cmd_m[6], cmd_m[2],
            cmd_m[2], cmd_m[1], cmd_m[0]});
         chk(vga_palette_hit, cmd_m[5] & e[0] & (a == 10'h3c6 ||
            a == 10'h3c8 || a == 10'h3c9));
         pulse(e);
         xfer(1'b0, 8'h04, 32'h0, q);
         chk(q, stw());
      end
      end_of_test();
   end
endmodule : tb_top
